// ==== common/sbt_pkg.sv ====
// Overview of operation
// - Serial test port with standard state sequencing and three-bit instructions.
// - Test clock runs only port logic; inputs sampled on its rising edge.
// - Serial data out and its enable change on falling test clock edges.
// - Undriven mode-select input reads as logic high.
// - Undriven serial data input reads as logic high.
// - Exactly one register, chosen by current instruction, sits between in and out.
// - Serial data in enters the most significant bit of the chosen register.
// - Serial data out shows the least significant bit of the chosen register.
// - Serial data out driven only in shifting states, inactive otherwise.
// - Port enters its reset state by itself at power-up, memory unaffected.
// - Mode select high for five rising edges resets the controller.
// - Instruction register is three bits, shifted in, applied on update.
// - Instruction register holds identification read after power-up and reset.
// - Instruction capture loads 01 into the two lowest instruction bits.
package sbt_pkg;

    localparam int SBT_IR_W = 3;
    localparam int SBT_ID_W = 32;
    localparam int SBT_BSR_W = 16;
    localparam int SBT_FIFO_DEPTH = 4;

    // Instruction codes
    localparam logic [2:0] SBT_INS_EXTEST = 3'h0;
    localparam logic [2:0] SBT_INS_IDCODE = 3'h1;
    localparam logic [2:0] SBT_INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] SBT_INS_SAMPLE = 3'h4;
    localparam logic [2:0] SBT_INS_BYPASS = 3'h7;

    // Pattern captured into the instruction shift stage
    localparam logic [2:0] SBT_IR_CAPTURE = 3'h1;

    // Identification word; value is arbitrary, bit 0 set as the scan chain expects
    localparam logic [31:0] SBT_ID_CODE = 32'h0A5A_0001;

    localparam logic [15:0] SBT_BSR_RST = 16'h0000;
    localparam logic SBT_BYPASS_CAPTURE = 1'h0;

    typedef enum logic [15:0] {
        SBT_ST_RESET   = 16'h0001,
        SBT_ST_IDLE    = 16'h0002,
        SBT_ST_SEL_DR  = 16'h0004,
        SBT_ST_CAP_DR  = 16'h0008,
        SBT_ST_SH_DR   = 16'h0010,
        SBT_ST_EX1_DR  = 16'h0020,
        SBT_ST_PAU_DR  = 16'h0040,
        SBT_ST_EX2_DR  = 16'h0080,
        SBT_ST_UPD_DR  = 16'h0100,
        SBT_ST_SEL_IR  = 16'h0200,
        SBT_ST_CAP_IR  = 16'h0400,
        SBT_ST_SH_IR   = 16'h0800,
        SBT_ST_EX1_IR  = 16'h1000,
        SBT_ST_PAU_IR  = 16'h2000,
        SBT_ST_EX2_IR  = 16'h4000,
        SBT_ST_UPD_IR  = 16'h8000
    } sbt_tap_state_t;

endpackage : sbt_pkg

// ==== hw/sbt_fifo.sv ====
`timescale 1ns/1ps
module sbt_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge i_clk_sys)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                                                             : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                                                             : rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : sbt_fifo

// ==== hw/sbt_sync.sv ====
`timescale 1ns/1ps
module sbt_sync #(
    parameter int W = 1
) (
    // Clock and clear
    input wire logic i_clk,
    input wire logic i_clr,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // Clear comes from a flip-flop, never from a pin
    always_ff @(posedge i_clk or posedge i_clr)
    begin
        if (i_clr)
        begin
            meta_reg <= '0;
            q_reg <= '0;
        end
        else
        begin
            meta_reg <= i_d;
            q_reg <= meta_reg;
        end
    end

    assign o_q = q_reg;

endmodule : sbt_sync

// ==== hw/sbt_tap_port.sv ====
`timescale 1ns/1ps
module sbt_tap_port (
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Test port pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tms_drv,
    input wire logic i_tdi,
    input wire logic i_tdi_drv,
    output logic o_tdo,
    output logic o_tdo_oe,
    // Pin ring snapshots from the memory core
    input wire logic i_cap_valid,
    output logic o_cap_ready,
    input wire logic [sbt_pkg::SBT_BSR_W-1:0] i_cap_data,
    // Instruction effects toward the memory core
    output logic o_extest,
    output logic o_sample_z
);

    localparam int BW = sbt_pkg::SBT_BSR_W;

    // System domain
    logic por_reg;
    logic fifo_valid;
    logic [BW-1:0] fifo_data;
    logic hs_req_reg;
    logic [BW-1:0] hs_data_reg;
    logic hs_ack_sync;
    logic hs_busy;
    logic [1:0] mode_sync;

    // Test clock domain
    logic rst_meta_reg;
    logic tap_rst;
    logic tms_in;
    logic tdi_in;
    sbt_pkg::sbt_tap_state_t state_reg;
    sbt_pkg::sbt_tap_state_t state_next;
    logic [2:0] ir_reg;
    logic [2:0] ir_sh_reg;
    logic bypass_reg;
    logic [sbt_pkg::SBT_ID_W-1:0] id_sh_reg;
    logic [BW-1:0] bsr_sh_reg;
    logic [BW-1:0] cap_word_reg;
    logic req_seen_reg;
    logic hs_ack_reg;
    logic hs_req_sync;
    logic dr_lsb;
    logic tdo_next;
    logic tdo_reg;
    logic tdo_oe_reg;
    logic sel_bsr;
    logic sel_id;

    // Power-up reset for the port; held one cycle past the system reset
    always_ff @(posedge i_clk_sys)
    begin
        por_reg <= !i_rst_b;
    end

    // Release into the test clock domain through two stages; assertion
    // is immediate so the output enable is defined with no test clock
    always_ff @(posedge i_tck or posedge por_reg)
    begin
        if (por_reg)
        begin
            rst_meta_reg <= 1'b1;
            tap_rst <= 1'b1;
        end
        else
        begin
            rst_meta_reg <= 1'b0;
            tap_rst <= rst_meta_reg;
        end
    end

    // Snapshot buffer; a stalled test clock backs up to the core
    sbt_fifo #(
        .W(BW),
        .DEPTH(sbt_pkg::SBT_FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_cap_valid),
        .o_in_ready(o_cap_ready),
        .i_in_data(i_cap_data),
        .o_out_valid(fifo_valid),
        .i_out_ready(!hs_busy),
        .o_out_data(fifo_data)
    );

    // Toggle handshake; the word stays still until the ack returns
    assign hs_busy = (hs_req_reg != hs_ack_sync);

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            hs_req_reg <= 1'b0;
            hs_data_reg <= sbt_pkg::SBT_BSR_RST;
        end
        else if (fifo_valid && !hs_busy)
        begin
            hs_req_reg <= !hs_req_reg;
            hs_data_reg <= fifo_data;
        end
    end

    sbt_sync #(
        .W(1)
    ) u_ack_sync (
        .i_clk(i_clk_sys),
        .i_clr(por_reg),
        .i_d(hs_ack_reg),
        .o_q(hs_ack_sync)
    );

    sbt_sync #(
        .W(1)
    ) u_req_sync (
        .i_clk(i_tck),
        .i_clr(tap_rst),
        .i_d(hs_req_reg),
        .o_q(hs_req_sync)
    );

    // Latest snapshot waits here for the next data capture
    always_ff @(posedge i_tck or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            req_seen_reg <= 1'b0;
            hs_ack_reg <= 1'b0;
            cap_word_reg <= sbt_pkg::SBT_BSR_RST;
        end
        else if (hs_req_sync != req_seen_reg)
        begin
            req_seen_reg <= hs_req_sync;
            hs_ack_reg <= hs_req_sync;
            cap_word_reg <= hs_data_reg;
        end
    end

    // Weak pulls on the pads: an undriven pin reads high
    assign tms_in = i_tms_drv ? i_tms : 1'b1;
    assign tdi_in = i_tdi_drv ? i_tdi : 1'b1;

    // Controller; five high mode-select edges reach reset from any state
    always_comb
    begin
        case (state_reg)
            sbt_pkg::SBT_ST_RESET:
                state_next = tms_in ? sbt_pkg::SBT_ST_RESET
                                    : sbt_pkg::SBT_ST_IDLE;
            sbt_pkg::SBT_ST_IDLE:
                state_next = tms_in ? sbt_pkg::SBT_ST_SEL_DR
                                    : sbt_pkg::SBT_ST_IDLE;
            sbt_pkg::SBT_ST_SEL_DR:
                state_next = tms_in ? sbt_pkg::SBT_ST_SEL_IR
                                    : sbt_pkg::SBT_ST_CAP_DR;
            sbt_pkg::SBT_ST_CAP_DR:
                state_next = tms_in ? sbt_pkg::SBT_ST_EX1_DR
                                    : sbt_pkg::SBT_ST_SH_DR;
            sbt_pkg::SBT_ST_SH_DR:
                state_next = tms_in ? sbt_pkg::SBT_ST_EX1_DR
                                    : sbt_pkg::SBT_ST_SH_DR;
            sbt_pkg::SBT_ST_EX1_DR:
                state_next = tms_in ? sbt_pkg::SBT_ST_UPD_DR
                                    : sbt_pkg::SBT_ST_PAU_DR;
            sbt_pkg::SBT_ST_PAU_DR:
                state_next = tms_in ? sbt_pkg::SBT_ST_EX2_DR
                                    : sbt_pkg::SBT_ST_PAU_DR;
            sbt_pkg::SBT_ST_EX2_DR:
                state_next = tms_in ? sbt_pkg::SBT_ST_UPD_DR
                                    : sbt_pkg::SBT_ST_SH_DR;
            sbt_pkg::SBT_ST_UPD_DR:
                state_next = tms_in ? sbt_pkg::SBT_ST_SEL_DR
                                    : sbt_pkg::SBT_ST_IDLE;
            sbt_pkg::SBT_ST_SEL_IR:
                state_next = tms_in ? sbt_pkg::SBT_ST_RESET
                                    : sbt_pkg::SBT_ST_CAP_IR;
            sbt_pkg::SBT_ST_CAP_IR:
                state_next = tms_in ? sbt_pkg::SBT_ST_EX1_IR
                                    : sbt_pkg::SBT_ST_SH_IR;
            sbt_pkg::SBT_ST_SH_IR:
                state_next = tms_in ? sbt_pkg::SBT_ST_EX1_IR
                                    : sbt_pkg::SBT_ST_SH_IR;
            sbt_pkg::SBT_ST_EX1_IR:
                state_next = tms_in ? sbt_pkg::SBT_ST_UPD_IR
                                    : sbt_pkg::SBT_ST_PAU_IR;
            sbt_pkg::SBT_ST_PAU_IR:
                state_next = tms_in ? sbt_pkg::SBT_ST_EX2_IR
                                    : sbt_pkg::SBT_ST_PAU_IR;
            sbt_pkg::SBT_ST_EX2_IR:
                state_next = tms_in ? sbt_pkg::SBT_ST_UPD_IR
                                    : sbt_pkg::SBT_ST_SH_IR;
            sbt_pkg::SBT_ST_UPD_IR:
                state_next = tms_in ? sbt_pkg::SBT_ST_SEL_DR
                                    : sbt_pkg::SBT_ST_IDLE;
            default:
                state_next = sbt_pkg::SBT_ST_RESET;
        endcase
    end

    // Only the test clock and the port reset move the controller
    always_ff @(posedge i_tck or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            state_reg <= sbt_pkg::SBT_ST_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Instruction path
    always_ff @(posedge i_tck or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            ir_reg <= sbt_pkg::SBT_INS_IDCODE;
            ir_sh_reg <= sbt_pkg::SBT_IR_CAPTURE;
        end
        else
        begin
            case (state_reg)
                sbt_pkg::SBT_ST_RESET:
                    ir_reg <= sbt_pkg::SBT_INS_IDCODE;
                sbt_pkg::SBT_ST_CAP_IR:
                    ir_sh_reg <= sbt_pkg::SBT_IR_CAPTURE;
                sbt_pkg::SBT_ST_SH_IR:
                    ir_sh_reg <= {tdi_in, ir_sh_reg[2:1]};
                sbt_pkg::SBT_ST_UPD_IR:
                    ir_reg <= ir_sh_reg;
                default:
                    ir_reg <= ir_reg;
            endcase
        end
    end

    // Register selection; private codes fall back to the bypass cell
    assign sel_bsr = (ir_reg == sbt_pkg::SBT_INS_EXTEST)
                  || (ir_reg == sbt_pkg::SBT_INS_SAMPLE)
                  || (ir_reg == sbt_pkg::SBT_INS_SAMPLE_Z);
    assign sel_id = (ir_reg == sbt_pkg::SBT_INS_IDCODE);

    // Data registers; each captures and shifts only when selected
    always_ff @(posedge i_tck or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            bypass_reg <= sbt_pkg::SBT_BYPASS_CAPTURE;
            id_sh_reg <= sbt_pkg::SBT_ID_CODE;
            bsr_sh_reg <= sbt_pkg::SBT_BSR_RST;
        end
        else if (state_reg == sbt_pkg::SBT_ST_CAP_DR)
        begin
            if (sel_bsr)
            begin
                bsr_sh_reg <= cap_word_reg;
            end
            else if (sel_id)
            begin
                id_sh_reg <= sbt_pkg::SBT_ID_CODE;
            end
            else
            begin
                bypass_reg <= sbt_pkg::SBT_BYPASS_CAPTURE;
            end
        end
        else if (state_reg == sbt_pkg::SBT_ST_SH_DR)
        begin
            if (sel_bsr)
            begin
                bsr_sh_reg <= {tdi_in, bsr_sh_reg[BW-1:1]};
            end
            else if (sel_id)
            begin
                id_sh_reg <= {tdi_in, id_sh_reg[31:1]};
            end
            else
            begin
                bypass_reg <= tdi_in;
            end
        end
    end

    assign dr_lsb = sel_bsr ? bsr_sh_reg[0]
                  : (sel_id ? id_sh_reg[0] : bypass_reg);
    assign tdo_next = (state_reg == sbt_pkg::SBT_ST_SH_IR) ? ir_sh_reg[0]
                                                           : dr_lsb;

    // Falling edge launch gives the controller half a period of hold
    always_ff @(negedge i_tck or posedge tap_rst)
    begin
        if (tap_rst)
        begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end
        else
        begin
            tdo_reg <= tdo_next;
            tdo_oe_reg <= (state_reg == sbt_pkg::SBT_ST_SH_IR)
                       || (state_reg == sbt_pkg::SBT_ST_SH_DR);
        end
    end

    assign o_tdo = tdo_reg;
    assign o_tdo_oe = tdo_oe_reg;

    // Instruction effects cross as slow levels
    sbt_sync #(
        .W(2)
    ) u_mode_sync (
        .i_clk(i_clk_sys),
        .i_clr(por_reg),
        .i_d({ir_reg == sbt_pkg::SBT_INS_EXTEST,
              ir_reg == sbt_pkg::SBT_INS_SAMPLE_Z}),
        .o_q(mode_sync)
    );

    assign o_extest = mode_sync[1];
    assign o_sample_z = mode_sync[0];

endmodule : sbt_tap_port

// ==== testbench/sbt_scan_host.sv ====
`timescale 1ns/1ps
module sbt_scan_host (
    // Test port pins
    output logic o_tck,
    output logic o_tms,
    output logic o_tms_drv,
    output logic o_tdi,
    output logic o_tdi_drv,
    input wire logic i_tdo,
    input wire logic i_tdo_oe
);
    // Test clock stands low between frames
    initial
    begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tms_drv = 1'b1;
        o_tdi = 1'b1;
        o_tdi_drv = 1'b1;
    end

    // A released pin shows the inverse of its last level, not the pull-up
    task automatic step(input logic tms, input logic tdi,
                        output logic tdo, output logic oe);
        o_tms = o_tms_drv ? tms : ~o_tms;
        o_tdi = o_tdi_drv ? tdi : ~o_tdi;
        #16;
        tdo = i_tdo;
        oe = i_tdo_oe;
        #16 o_tck = 1'b1;
        #32 o_tck = 1'b0;
    endtask : step

    task automatic hold_tms(input int n, input logic drv);
        logic t;
        logic e;
        o_tms_drv = drv;
        repeat (n) step(1'b1, 1'b1, t, e);
        o_tms_drv = 1'b1;
    endtask : hold_tms

    task automatic float_tdi(input logic f);
        o_tdi_drv = ~f;
    endtask : float_tdi

    // Works from Idle or from reset
    task automatic to_shift(input logic ir);
        logic t;
        logic e;
        step(1'b0, 1'b0, t, e);
        step(1'b1, 1'b0, t, e);
        if (ir)
            step(1'b1, 1'b0, t, e);
        step(1'b0, 1'b0, t, e);
        step(1'b0, 1'b0, t, e);
    endtask : to_shift
endmodule : sbt_scan_host

// ==== testbench/sbt_tap_port_monitor.sv ====
`timescale 1ns/1ps
module sbt_tap_port_monitor (
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Test port pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tms_drv,
    input wire logic i_tdi,
    input wire logic i_tdi_drv,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    // Snapshot path
    input wire logic i_cap_valid,
    input wire logic o_cap_ready,
    input wire logic [sbt_pkg::SBT_BSR_W-1:0] i_cap_data,
    // Instruction effects
    input wire logic o_extest,
    input wire logic o_sample_z
);
    logic tms_eff;
    logic rise_move_reg = 1'b0;
    assign tms_eff = i_tms | ~i_tms_drv;

    // Output moving while the test clock is high means a rising-edge launch
    always @(o_tdo or o_tdo_oe)
    begin
        if (i_tck === 1'b1)
            rise_move_reg <= 1'b1;
    end

    sequence s_reset5;
        tms_eff [*5];
    endsequence
    sequence s_to_dr;
        !tms_eff ##1 tms_eff ##1 !tms_eff ##1 !tms_eff;
    endsequence
    sequence s_to_ir;
        !tms_eff ##1 tms_eff ##1 tms_eff ##1 !tms_eff ##1 !tms_eff;
    endsequence

    property p_tms_reset;
        @(posedge i_tck) disable iff (!i_rst_b) s_reset5 |=> !o_tdo_oe;
    endproperty
    property p_walk_dr;
        @(posedge i_tck) disable iff (!i_rst_b) s_reset5 ##1 s_to_dr |=>
            o_tdo_oe && o_tdo == sbt_pkg::SBT_ID_CODE[0];
    endproperty
    property p_walk_ir;
        @(posedge i_tck) disable iff (!i_rst_b) s_reset5 ##1 s_to_ir |=>
            o_tdo_oe && o_tdo == sbt_pkg::SBT_IR_CAPTURE[0];
    endproperty
    property p_oe_needs_zero;
        @(posedge i_tck) disable iff (!i_rst_b) o_tdo_oe |-> !$past(tms_eff);
    endproperty
    property p_oe_drop;
        @(posedge i_tck) disable iff (!i_rst_b)
            o_tdo_oe && tms_eff |=> !o_tdo_oe;
    endproperty
    property p_fall_launch;
        @(posedge i_clk_sys) disable iff (!i_rst_b) !rise_move_reg;
    endproperty
    property p_rel_quiet;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
            $rose(i_rst_b) |-> !o_extest && !o_sample_z && o_cap_ready;
    endproperty
    property p_rel_oe;
        @(posedge i_clk_sys) disable iff (!i_rst_b) $rose(i_rst_b) |-> !o_tdo_oe;
    endproperty
    property p_one_path;
        @(posedge i_clk_sys) disable iff (!i_rst_b) !(o_extest && o_sample_z);
    endproperty

    a_tms_reset: assert property (p_tms_reset)
        else $error("tdo enabled after five mode-select highs");
    a_walk_dr: assert property (p_walk_dr)
        else $error("identification bit not first on data shift");
    a_walk_ir: assert property (p_walk_ir)
        else $error("capture pattern bit not first on instruction shift");
    a_oe_needs_zero: assert property (p_oe_needs_zero)
        else $error("tdo enabled outside a shift state");
    a_oe_drop: assert property (p_oe_drop)
        else $error("tdo enable held after leaving shift");
    a_fall_launch: assert property (p_fall_launch)
        else $error("tdo changed while test clock high");
    a_rel_quiet: assert property (p_rel_quiet)
        else $error("instruction effects or ready wrong after reset");
    a_rel_oe: assert property (p_rel_oe)
        else $error("tdo enabled during reset");
    a_one_path: assert property (p_one_path)
        else $error("two instruction effects at once");
endmodule : sbt_tap_port_monitor

// ==== testbench/sbt_tap_port_tb.sv ====
`timescale 1ns/1ps
module sbt_tap_port_tb;
    logic i_clk_sys, i_rst_b, i_tck, i_tms, i_tms_drv, i_tdi, i_tdi_drv;
    logic o_tdo, o_tdo_oe, i_cap_valid, o_cap_ready, o_extest, o_sample_z;
    logic [sbt_pkg::SBT_BSR_W-1:0] i_cap_data;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;

    sbt_tap_port dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_tck(i_tck), .i_tms(i_tms), .i_tms_drv(i_tms_drv), .i_tdi(i_tdi),
        .i_tdi_drv(i_tdi_drv), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
        .i_cap_valid(i_cap_valid), .o_cap_ready(o_cap_ready),
        .i_cap_data(i_cap_data), .o_extest(o_extest),
        .o_sample_z(o_sample_z));
    sbt_scan_host host (.o_tck(i_tck), .o_tms(i_tms), .o_tms_drv(i_tms_drv),
        .o_tdi(i_tdi), .o_tdi_drv(i_tdi_drv), .i_tdo(o_tdo),
        .i_tdo_oe(o_tdo_oe));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    task automatic test_done;
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // A hung handshake ends the run as a failure
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            n_fail++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [63:0] exp, got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic shift(input int n, input logic [63:0] din,
                         output logic [63:0] dout);
        logic t;
        logic e;
        dout = 64'h0;
        for (int i = 0; i < n; i++)
        begin
            host.step(i == n - 1, din[i], t, e);
            dout[i] = t;
            check("tdo enable in shift", 64'h1, e);
        end
        host.step(1'b1, 1'b0, t, e);
        host.step(1'b0, 1'b0, t, e);
        check("tdo enable in idle", 64'h0, e);
    endtask : shift

    task automatic load_ir(input logic [2:0] code);
        logic [63:0] d;
        host.to_shift(1'b1);
        shift(3, {61'h0, code}, d);
        check("capture pattern", sbt_pkg::SBT_IR_CAPTURE, d);
    endtask : load_ir

    task automatic wait_flags(input logic ext, input logic smz);
        for (int i = 0; i < 20; i++)
        begin
            @(negedge i_clk_sys);
            if (o_extest === ext && o_sample_z === smz)
                break;
        end
        check("extest flag", ext, o_extest);
        check("sample_z flag", smz, o_sample_z);
    endtask : wait_flags

    task automatic t_power;
        @(negedge i_clk_sys);
        check("tdo enable after reset", 64'h0, o_tdo_oe);
        check("ready after reset", 64'h1, o_cap_ready);
    endtask : t_power

    // Undriven tdi must shift in ones behind the identification word
    task automatic t_id(input int n_hi, input logic tms_drv);
        logic [63:0] d;
        host.hold_tms(n_hi, tms_drv);
        host.float_tdi(1'b1);
        host.to_shift(1'b0);
        shift(64, 64'h0, d);
        host.float_tdi(1'b0);
        check("id word", {32'hFFFF_FFFF, sbt_pkg::SBT_ID_CODE}, d);
    endtask : t_id

    task automatic t_bypass;
        logic [63:0] d;
        load_ir(sbt_pkg::SBT_INS_BYPASS);
        host.to_shift(1'b0);
        shift(8, 64'hA5, d);
        check("bypass path", 64'h4A, d);
    endtask : t_bypass

    // Path length per instruction shows which register sits in the chain
    task automatic t_codes;
        logic [63:0] d;
        logic [63:0] pat;
        int len;
        pat = 64'h0000_9C3A_65F1_D2B7;
        for (int c = 0; c < 8; c++)
        begin
            load_ir(3'(c));
            wait_flags(c == 0, c == 2);
            len = (c == 1) ? 32 : ((c == 0 || c == 2 || c == 4) ? 16 : 1);
            host.to_shift(1'b0);
            shift(48, pat, d);
            check("path tail", pat & ((64'h1 << (48 - len)) - 64'h1),
                  d >> len);
        end
    endtask : t_codes

    // Fill the buffer with the test clock stopped, then capture the last word
    task automatic t_snap;
        logic ok;
        int took;
        logic [63:0] d;
        logic t;
        logic e;
        took = 0;
        ok = 1'b1;
        @(posedge i_clk_sys);
        while (ok && took < 8)
        begin
            i_cap_valid <= 1'b1;
            i_cap_data <= 16'hC350 + 16'(took);
            @(negedge i_clk_sys);
            ok = o_cap_ready;
            @(posedge i_clk_sys);
            if (ok)
                took++;
        end
        check("buffer refuses", 64'h0, ok);
        check("buffer depth", 64'h1, took >= sbt_pkg::SBT_FIFO_DEPTH);
        fork
            begin
                // Mode-select reset first, so the instruction walk follows it
                host.hold_tms(5, 1'b1);
                load_ir(sbt_pkg::SBT_INS_SAMPLE);
                repeat (40) host.step(1'b0, 1'b0, t, e);
            end
            begin
                for (int i = 0; i < 4000; i++)
                begin
                    @(negedge i_clk_sys);
                    if (o_cap_ready)
                        break;
                end
                @(posedge i_clk_sys);
                i_cap_valid <= 1'b0;
            end
        join
        host.to_shift(1'b0);
        shift(16, 64'h0, d);
        check("snapshot word", 16'hC350 + 16'(took), d);
    endtask : t_snap

    // System reset in mid-shift must drop the enable with the test clock low
    task automatic t_rereset;
        load_ir(sbt_pkg::SBT_INS_EXTEST);
        wait_flags(1'b1, 1'b0);
        host.to_shift(1'b0);
        @(posedge i_clk_sys);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check("extest in reset", 64'h0, o_extest);
        check("tdo enable in reset", 64'h0, o_tdo_oe);
        @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        @(negedge i_clk_sys);
        t_id(3, 1'b1);
    endtask : t_rereset

    initial
    begin
        i_rst_b = 1'b0;
        i_cap_valid = 1'b0;
        i_cap_data = 16'h0000;
        repeat (8) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        t_power();
        t_id(3, 1'b1);
        t_bypass();
        t_codes();
        t_id(5, 1'b0);
        t_snap();
        t_rereset();
        test_done();
    end
endmodule : sbt_tap_port_tb

bind sbt_tap_port sbt_tap_port_monitor u_mon (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_tck(i_tck), .i_tms(i_tms), .i_tms_drv(i_tms_drv),
    .i_tdi(i_tdi), .i_tdi_drv(i_tdi_drv), .o_tdo(o_tdo),
    .o_tdo_oe(o_tdo_oe), .i_cap_valid(i_cap_valid),
    .o_cap_ready(o_cap_ready), .i_cap_data(i_cap_data),
    .o_extest(o_extest), .o_sample_z(o_sample_z));
